//--- shared/fpi_pkg.sv
// Overview of operation
// - Byte count follows data port writes/reads; a write and read in one cycle on a non-empty queue count as a read only
// - Large mode extends count via control bits
// - Data port accesses keep address pointer
// - Flags A: bit 7 selects set/clear
// - Flags B: bit 7 selects set/clear
// - Latch high-level event on alert rising
// - Latch low-level event until cleared
// - Command done when command self-terminates
// - Unknown command returns idle, sets done
// - Host idle write sets no done
// - Transmit done on final bit sent
// - Receive end regardless of stream errors
// - Error event on any listed error
// - Frame start on SOF or subcarrier
// - Combined request from enabled active sources
// - Card sense event on card detection
// - One flag per timer underflow
// - Source counts only while enabled
// - Pin follows combined only when enabled
// - Inversion bit inverts pin polarity
// - Low alert when count at or below threshold
package fpi_pkg;
  localparam int unsigned AW = 8;
  localparam int unsigned DW = 8;
  localparam logic [AW-1:0] ADDR_CMD = 8'h00;
  localparam logic [AW-1:0] ADDR_QCTRL = 8'h02;
  localparam logic [AW-1:0] ADDR_WATER = 8'h03;
  localparam logic [AW-1:0] ADDR_COUNT = 8'h04;
  localparam logic [AW-1:0] ADDR_DATA = 8'h05;
  localparam logic [AW-1:0] ADDR_FLAGS_A = 8'h06;
  localparam logic [AW-1:0] ADDR_FLAGS_B = 8'h07;
  localparam logic [AW-1:0] ADDR_EN_A = 8'h08;
  localparam logic [AW-1:0] ADDR_EN_B = 8'h09;
  localparam logic [AW-1:0] ADDR_STEP = 8'h01;
  localparam logic [DW-1:0] RST_BYTE = 8'h00;
  localparam int unsigned QC_SIZE_BIT = 7;
  localparam int unsigned QC_FLUSH_BIT = 4;
  localparam int unsigned QC_WEXT_BIT = 2;
  localparam int unsigned SET_BIT = 7;
  localparam int unsigned EA_INV_BIT = 7;
  localparam int unsigned EB_PP_BIT = 7;
  localparam int unsigned EB_PIN_BIT = 6;
  localparam int unsigned FA_W = 7;
  localparam int unsigned FB_W = 6;
  localparam int unsigned TMR_N = 5;
  localparam int unsigned QDEPTH = 512;
  localparam int unsigned QPW = 9;
  localparam int unsigned QCW = 10;
  localparam logic [QCW-1:0] Q_SMALL = 10'h0ff;
  localparam logic [QCW-1:0] Q_LARGE = 10'h200;
  localparam int unsigned CMD_W = 5;
  localparam logic [CMD_W-1:0] CMD_IDLE = 5'h00;
  // Highest accepted command code; anything above is unknown
  localparam logic [CMD_W-1:0] CMD_MAX_KNOWN = 5'h0f;
endpackage

//--- hdl/fpi_top.sv
// Our own choice: strobed register access.
module fpi_top (
  input wire logic i_ref_clk,
  input wire logic i_rst,
  input wire logic [fpi_pkg::AW-1:0] i_addr,
  input wire logic [fpi_pkg::DW-1:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [fpi_pkg::DW-1:0] o_rdata,
  output logic [fpi_pkg::AW-1:0] o_addr_ptr,
  output logic [fpi_pkg::CMD_W-1:0] o_command,
  input wire logic i_command_finished,
  input wire logic i_tx_last_bit,
  input wire logic i_rx_end,
  input wire logic i_frame_start,
  input wire logic i_card_sense,
  input wire logic [fpi_pkg::TMR_N-1:0] i_timer_underflow,
  input wire logic i_queue_write_error,
  input wire logic i_protocol_error,
  input wire logic i_missing_data_error,
  input wire logic i_integrity_error,
  output logic o_queue_overflow_error,
  output logic o_irq_pin,
  output logic o_irq_pin_oe_n
);
  import fpi_pkg::*;

  logic [DW-1:0] mem [QDEPTH];
  logic [QPW-1:0] wr_ptr_r;
  logic [QPW-1:0] rd_ptr_r;
  logic [QCW-1:0] count_r;
  logic size_small_r;
  logic wext_r;
  logic [DW-1:0] water_r;
  logic hi_prev_r;
  logic lo_prev_r;
  logic [CMD_W-1:0] cmd_r;
  logic [FA_W-1:0] flags_a_r;
  logic [FA_W-1:0] flags_a_nxt;
  logic [FB_W-1:0] flags_b_r;
  logic [FB_W-1:0] flags_b_nxt;
  logic [DW-1:0] en_a_r;
  logic [DW-1:0] en_b_r;
  logic [DW-1:0] rdata_r;
  logic [DW-1:0] rdata_nxt;
  logic [AW-1:0] ptr_r;
  logic ovf_r;
  logic pin_r;
  logic pin_oe_n_r;

  logic wr_data;
  logic rd_data;
  logic wr_qctrl;
  logic [QCW-1:0] capacity;
  logic full;
  logic push;
  logic pop;
  logic overflow;
  logic flush;
  logic [QCW-1:0] water_lvl;
  logic hi_alert;
  logic lo_alert;
  logic cmd_wr;
  logic unknown_start;
  logic cmd_done;
  logic err_any;
  logic [FA_W-1:0] hw_a;
  logic [FB_W-1:0] hw_b;
  logic combined;
  logic pin_level;
  logic pin_active;
  logic wr_water;
  logic wr_en_a;
  logic wr_en_b;
  logic wr_flags_a;
  logic wr_flags_b;
  logic hi_rise;
  logic lo_rise;
  logic [QCW-DW-1:0] count_ext;
  logic [DW-1:0] qctrl_view;

  assign wr_data = i_wr && (i_addr == ADDR_DATA);
  assign rd_data = i_rd && (i_addr == ADDR_DATA);
  assign wr_qctrl = i_wr && (i_addr == ADDR_QCTRL);
  assign wr_water = i_wr && (i_addr == ADDR_WATER);
  assign wr_en_a = i_wr && (i_addr == ADDR_EN_A);
  assign wr_en_b = i_wr && (i_addr == ADDR_EN_B);
  assign wr_flags_a = i_wr && (i_addr == ADDR_FLAGS_A);
  assign wr_flags_b = i_wr && (i_addr == ADDR_FLAGS_B);
  assign flush = wr_qctrl && i_wdata[QC_FLUSH_BIT];
  assign capacity = size_small_r ? Q_SMALL : Q_LARGE;
  assign full = (count_r >= capacity);
  // Writes into a full queue are dropped, never wrap over old data
  assign push = wr_data && !full;
  assign pop = rd_data && (count_r != '0);
  assign overflow = wr_data && full;

  // Threshold extension bit only counts in large mode
  assign water_lvl = {1'b0, wext_r && !size_small_r, water_r};
  assign hi_alert = ((capacity - count_r) <= water_lvl);
  assign lo_alert = (count_r <= water_lvl);
  assign hi_rise = hi_alert && !hi_prev_r;
  assign lo_rise = lo_alert && !lo_prev_r;

  // Upper count bits read as zero in small mode
  assign count_ext = size_small_r ? '0 : count_r[QCW-1:DW];
  assign qctrl_view = {size_small_r, hi_alert, lo_alert, 2'h0, wext_r,
    count_ext};

  assign cmd_wr = i_wr && (i_addr == ADDR_CMD);
  assign unknown_start = cmd_wr
    && (i_wdata[CMD_W-1:0] > CMD_MAX_KNOWN);
  // Host writing idle is not a termination on its own
  assign cmd_done = unknown_start
    || (i_command_finished && (cmd_r != CMD_IDLE));

  // A write dropped at a full queue counts as an overflow error
  assign err_any = i_queue_write_error || overflow || i_protocol_error
    || i_missing_data_error || i_integrity_error;

  assign hw_a = {hi_rise,
                 lo_rise,
                 cmd_done,
                 i_tx_last_bit,
                 i_rx_end,
                 err_any,
                 i_frame_start};
  // Timer n lands in flag bit n
  assign hw_b = {i_card_sense, i_timer_underflow};

  // Recomputed every cycle so it drops with its sources
  assign combined = (|(flags_a_r & en_a_r[FA_W-1:0]))
    || (|(flags_b_r & en_b_r[FB_W-1:0]));
  assign pin_active = en_b_r[EB_PIN_BIT] && combined;
  // A disabled pin rests at the inactive level set by the invert bit
  assign pin_level = pin_active ^ en_a_r[EA_INV_BIT];

  // No reset on the storage; only the pointers and the count need a known start
  always_ff @(posedge i_ref_clk)
  begin
    if (push)
    begin
      mem[wr_ptr_r] <= i_wdata;
    end
  end

  always_ff @(posedge i_ref_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
      count_r <= '0;
    end
    else if (flush)
    begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
      count_r <= '0;
    end
    else
    begin
      if (push)
      begin
        wr_ptr_r <= wr_ptr_r + 1'b1;
        count_r <= count_r + 1'b1;
      end
      if (pop)
      begin
        rd_ptr_r <= rd_ptr_r + 1'b1;
        count_r <= count_r - 1'b1;
      end
    end
  end

  always_ff @(posedge i_ref_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      size_small_r <= 1'b0;
      wext_r <= 1'b0;
      water_r <= RST_BYTE;
    end
    else
    begin
      if (wr_qctrl)
      begin
        size_small_r <= i_wdata[QC_SIZE_BIT];
        wext_r <= i_wdata[QC_WEXT_BIT];
      end
      if (wr_water)
      begin
        water_r <= i_wdata;
      end
    end
  end

  // Start high so the alert level present at reset is no event
  always_ff @(posedge i_ref_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      hi_prev_r <= 1'b1;
      lo_prev_r <= 1'b1;
    end
    else
    begin
      hi_prev_r <= hi_alert;
      lo_prev_r <= lo_alert;
    end
  end

  // A host write wins over a finish landing in the same cycle
  always_ff @(posedge i_ref_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      cmd_r <= CMD_IDLE;
    end
    else if (cmd_wr)
    begin
      cmd_r <= unknown_start ? CMD_IDLE : i_wdata[CMD_W-1:0];
    end
    else if (i_command_finished)
    begin
      cmd_r <= CMD_IDLE;
    end
  end

  // One cell per request flag; the hardware set is applied after the
  // software write, so an event meeting a clear is never lost
  for (genvar b = 0; b < FA_W; b++)
  begin : g_flag_a
    always_comb
    begin
      flags_a_nxt[b] = flags_a_r[b];
      if (wr_flags_a && i_wdata[b])
      begin
        flags_a_nxt[b] = i_wdata[SET_BIT];
      end
      if (hw_a[b])
      begin
        flags_a_nxt[b] = 1'b1;
      end
    end

    always_ff @(posedge i_ref_clk or posedge i_rst)
    begin
      if (i_rst)
      begin
        flags_a_r[b] <= 1'b0;
      end
      else
      begin
        flags_a_r[b] <= flags_a_nxt[b];
      end
    end
  end

  for (genvar b = 0; b < FB_W; b++)
  begin : g_flag_b
    always_comb
    begin
      flags_b_nxt[b] = flags_b_r[b];
      if (wr_flags_b && i_wdata[b])
      begin
        flags_b_nxt[b] = i_wdata[SET_BIT];
      end
      if (hw_b[b])
      begin
        flags_b_nxt[b] = 1'b1;
      end
    end

    always_ff @(posedge i_ref_clk or posedge i_rst)
    begin
      if (i_rst)
      begin
        flags_b_r[b] <= 1'b0;
      end
      else
      begin
        flags_b_r[b] <= flags_b_nxt[b];
      end
    end
  end

  always_ff @(posedge i_ref_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      en_a_r <= RST_BYTE;
      en_b_r <= RST_BYTE;
    end
    else
    begin
      if (wr_en_a)
      begin
        en_a_r <= i_wdata;
      end
      if (wr_en_b)
      begin
        en_b_r <= i_wdata;
      end
    end
  end

  // Open drain drives only the low level; high is left to the pull-up
  always_ff @(posedge i_ref_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      pin_r <= 1'b0;
      pin_oe_n_r <= 1'b1;
    end
    else
    begin
      pin_r <= pin_level;
      pin_oe_n_r <= !en_b_r[EB_PP_BIT] && pin_level;
    end
  end

  // Data port is one address, so streaming never walks off it
  always_ff @(posedge i_ref_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      ptr_r <= RST_BYTE;
    end
    else if (i_wr || i_rd)
    begin
      ptr_r <= (i_addr == ADDR_DATA) ? i_addr : i_addr + ADDR_STEP;
    end
  end

  // Zero outside the answer cycle so a stale byte is never taken twice
  always_comb
  begin
    rdata_nxt = RST_BYTE;
    if (i_rd)
    begin
      case (i_addr)
        ADDR_CMD: rdata_nxt = {3'h0, cmd_r};
        ADDR_QCTRL: rdata_nxt = qctrl_view;
        ADDR_WATER: rdata_nxt = water_r;
        ADDR_COUNT: rdata_nxt = count_r[DW-1:0];
        ADDR_DATA: rdata_nxt = pop ? mem[rd_ptr_r] : RST_BYTE;
        ADDR_FLAGS_A: rdata_nxt = {1'b0, flags_a_r};
        ADDR_FLAGS_B: rdata_nxt = {1'b0, combined, flags_b_r};
        ADDR_EN_A: rdata_nxt = en_a_r;
        ADDR_EN_B: rdata_nxt = en_b_r;
        default: rdata_nxt = RST_BYTE;
      endcase
    end
  end

  always_ff @(posedge i_ref_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      rdata_r <= RST_BYTE;
      ovf_r <= 1'b0;
    end
    else
    begin
      rdata_r <= rdata_nxt;
      ovf_r <= overflow;
    end
  end

  assign o_rdata = rdata_r;
  assign o_addr_ptr = ptr_r;
  assign o_command = cmd_r;
  assign o_queue_overflow_error = ovf_r;
  assign o_irq_pin = pin_r;
  assign o_irq_pin_oe_n = pin_oe_n_r;
endmodule

//--- tb/fpi_chk.sv
module fpi_chk (
  input wire logic i_ref_clk,
  input wire logic i_rst,
  input wire logic [fpi_pkg::AW-1:0] i_addr,
  input wire logic [fpi_pkg::DW-1:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  input wire logic [fpi_pkg::DW-1:0] o_rdata,
  input wire logic [fpi_pkg::AW-1:0] o_addr_ptr,
  input wire logic [fpi_pkg::CMD_W-1:0] o_command,
  input wire logic i_command_finished,
  input wire logic i_tx_last_bit,
  input wire logic [fpi_pkg::TMR_N-1:0] i_timer_underflow
);
  timeunit 1ns;
  timeprecision 1ns;
  import fpi_pkg::*;
  default clocking @(posedge i_ref_clk); endclocking
  default disable iff (i_rst);
  ptr_hold_a: assert property (
    (i_wr || i_rd) && i_addr == ADDR_DATA |=> o_addr_ptr == ADDR_DATA)
    else $error("pointer moved");
  ptr_step_a: assert property (
    (i_wr || i_rd) && i_addr != ADDR_DATA
    |=> o_addr_ptr == $past(i_addr) + ADDR_STEP)
    else $error("pointer not stepped");
  cmd_bad_a: assert property (
    i_wr && i_addr == ADDR_CMD && i_wdata[4:0] > CMD_MAX_KNOWN
    |=> o_command == CMD_IDLE)
    else $error("unknown command kept");
  cmd_end_a: assert property (
    i_command_finished && o_command != CMD_IDLE
    && !(i_wr && i_addr == ADDR_CMD) |=> o_command == CMD_IDLE)
    else $error("command not idled");
  tx_flag_a: assert property (
    i_tx_last_bit ##1 i_rd && i_addr == ADDR_FLAGS_A |=> o_rdata[3])
    else $error("transmit flag missing");
  tmr_flag_a: assert property (
    i_timer_underflow[0] ##1 !i_wr ##1 i_rd && i_addr == ADDR_FLAGS_B
    |=> o_rdata[0])
    else $error("timer flag missing");
  set_all_a: assert property (
    i_wr && i_addr == ADDR_FLAGS_A && i_wdata == 8'hff
    ##1 i_rd && i_addr == ADDR_FLAGS_A |=> o_rdata == 8'h7f)
    else $error("flags a not all set");
  setb_all_a: assert property (
    i_wr && i_addr == ADDR_FLAGS_B && i_wdata == 8'hff
    ##1 i_rd && i_addr == ADDR_FLAGS_B |=> o_rdata[5:0] == 6'h3f)
    else $error("flags b not all set");
endmodule
bind fpi_top fpi_chk chk_u (
  .i_ref_clk(i_ref_clk),
  .i_rst(i_rst),
  .i_addr(i_addr),
  .i_wdata(i_wdata),
  .i_wr(i_wr),
  .i_rd(i_rd),
  .o_rdata(o_rdata),
  .o_addr_ptr(o_addr_ptr),
  .o_command(o_command),
  .i_command_finished(i_command_finished),
  .i_tx_last_bit(i_tx_last_bit),
  .i_timer_underflow(i_timer_underflow)
);

//--- tb/fpi_host.sv
module fpi_host (
  input wire logic i_ref_clk,
  input wire logic [fpi_pkg::DW-1:0] i_rdata,
  output logic [fpi_pkg::AW-1:0] o_addr,
  output logic [fpi_pkg::DW-1:0] o_wdata,
  output logic o_wr,
  output logic o_rd
);
  timeunit 1ns;
  timeprecision 1ns;
  initial
  begin
    o_addr = 8'h00;
    o_wdata = 8'h00;
    o_wr = 1'b0;
    o_rd = 1'b0;
  end
  // Entered just after an edge; strobe sampled at the next one
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    o_addr <= a;
    o_wdata <= d;
    o_wr <= 1'b1;
    @(posedge i_ref_clk);
    o_wr <= 1'b0;
    #1;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    o_addr <= a;
    o_rd <= 1'b1;
    @(posedge i_ref_clk);
    o_rd <= 1'b0;
    #1 d = i_rdata;
  endtask
endmodule

//--- tb/fpi_top_tb.sv
module fpi_top_tb;
  timeunit 1ns;
  timeprecision 1ns;
  import fpi_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [13:0] ev = 14'h0;
  logic [7:0] addr, wdata, rdata, ptr, d;
  logic wr, rd, ovf, pin, oen;
  logic [4:0] cmd;
  int failures = 0;
  int compares = 0;
  always #5 clk = ~clk;
  fpi_host host_u (.i_ref_clk(clk), .i_rdata(rdata), .o_addr(addr),
    .o_wdata(wdata), .o_wr(wr), .o_rd(rd));
  fpi_top dut_u (.i_ref_clk(clk), .i_rst(rst), .i_addr(addr),
    .i_wdata(wdata), .i_wr(wr), .i_rd(rd), .o_rdata(rdata),
    .o_addr_ptr(ptr), .o_command(cmd), .i_command_finished(ev[0]),
    .i_tx_last_bit(ev[1]), .i_rx_end(ev[2]), .i_frame_start(ev[3]),
    .i_card_sense(ev[4]), .i_timer_underflow(ev[9:5]),
    .i_queue_write_error(ev[10]), .i_protocol_error(ev[11]),
    .i_missing_data_error(ev[12]), .i_integrity_error(ev[13]),
    .o_queue_overflow_error(ovf), .o_irq_pin(pin), .o_irq_pin_oe_n(oen));
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp)
    begin
      failures++;
      $display("[ERR] %0t got %h want %h", $time, got, exp);
    end
  endtask
  task automatic rc(input logic [7:0] a, input logic [7:0] e);
    host_u.rd(a, d);
    chk(d, e);
  endtask
  task automatic pulse(input int i);
    ev <= 14'h1 << i;
    @(posedge clk);
    ev <= 14'h0;
    #1;
  endtask
  task automatic t_flags;
    rc(ADDR_FLAGS_A, 8'h00);
    rc(8'h20, 8'h00);
    chk(ptr, 8'h21);
    host_u.wr(ADDR_FLAGS_A, 8'hff);
    rc(ADDR_FLAGS_A, 8'h7f);
    host_u.wr(ADDR_FLAGS_A, 8'h7a);
    rc(ADDR_FLAGS_A, 8'h05);
    host_u.wr(ADDR_FLAGS_B, 8'hff);
    rc(ADDR_FLAGS_B, 8'h3f);
    host_u.wr(ADDR_FLAGS_B, 8'h3e);
    host_u.wr(ADDR_EN_B, 8'h42);
    rc(ADDR_FLAGS_B, 8'h01);
    chk({7'h0, pin}, 8'h00);
    host_u.wr(ADDR_EN_B, 8'h41);
    rc(ADDR_FLAGS_B, 8'h41);
    chk({7'h0, pin}, 8'h01);
    chk({7'h0, oen}, 8'h01);
    host_u.wr(ADDR_EN_B, 8'h01);
    rc(ADDR_FLAGS_B, 8'h41);
    chk({7'h0, pin}, 8'h00);
    host_u.wr(ADDR_EN_B, 8'hc1);
    host_u.wr(ADDR_EN_A, 8'h80);
    rc(ADDR_EN_A, 8'h80);
    chk({7'h0, pin}, 8'h00);
    host_u.wr(ADDR_FLAGS_B, 8'h01);
    rc(ADDR_FLAGS_B, 8'h00);
    chk({7'h0, pin}, 8'h01);
    chk({7'h0, oen}, 8'h00);
    // Clear and event on the same edge
    fork
      host_u.wr(ADDR_FLAGS_A, 8'h7f);
      pulse(1);
    join
    rc(ADDR_FLAGS_A, 8'h08);
    host_u.wr(ADDR_FLAGS_A, 8'h7f);
    host_u.wr(ADDR_EN_A, 8'h00);
    host_u.wr(ADDR_EN_B, 8'h00);
    $display("flags done");
  endtask
  task automatic t_events;
    logic [15:0] e;
    for (int i = 1; i < 14; i++)
    begin
      e = i == 1 ? 16'h0008 : i == 2 ? 16'h0004 : i == 3 ? 16'h0001
        : i == 4 ? 16'h2000 : i < 10 ? 16'h0100 << (i - 5) : 16'h0002;
      pulse(i);
      rc(ADDR_FLAGS_A, e[7:0]);
      rc(ADDR_FLAGS_B, e[15:8]);
      host_u.wr(ADDR_FLAGS_A, 8'h7f);
      host_u.wr(ADDR_FLAGS_B, 8'h3f);
    end
    $display("events done");
  endtask
  task automatic t_cmd;
    host_u.wr(ADDR_CMD, 8'h05);
    chk({3'h0, cmd}, 8'h05);
    pulse(0);
    chk({3'h0, cmd}, 8'h00);
    rc(ADDR_FLAGS_A, 8'h10);
    host_u.wr(ADDR_FLAGS_A, 8'h7f);
    host_u.wr(ADDR_CMD, 8'h1f);
    chk({3'h0, cmd}, 8'h00);
    rc(ADDR_FLAGS_A, 8'h10);
    host_u.wr(ADDR_FLAGS_A, 8'h7f);
    host_u.wr(ADDR_CMD, 8'h05);
    host_u.wr(ADDR_CMD, 8'h00);
    rc(ADDR_FLAGS_A, 8'h00);
    $display("command done");
  endtask
  task automatic t_queue;
    for (int i = 0; i < 512; i++)
      host_u.wr(ADDR_DATA, 8'(i));
    chk(ptr, ADDR_DATA);
    rc(ADDR_COUNT, 8'h00);
    rc(ADDR_QCTRL, 8'h42);
    rc(ADDR_FLAGS_A, 8'h40);
    host_u.wr(ADDR_DATA, 8'h5a);
    chk({7'h0, ovf}, 8'h01);
    rc(ADDR_FLAGS_A, 8'h42);
    rc(ADDR_DATA, 8'h00);
    rc(ADDR_DATA, 8'h01);
    rc(ADDR_COUNT, 8'hfe);
    rc(ADDR_QCTRL, 8'h01);
    host_u.wr(ADDR_QCTRL, 8'h10);
    rc(ADDR_QCTRL, 8'h20);
    rc(ADDR_FLAGS_A, 8'h62);
    host_u.wr(ADDR_WATER, 8'h02);
    host_u.wr(ADDR_DATA, 8'h11);
    host_u.wr(ADDR_DATA, 8'h22);
    rc(ADDR_QCTRL, 8'h20);
    host_u.wr(ADDR_DATA, 8'h33);
    rc(ADDR_QCTRL, 8'h00);
    rc(ADDR_DATA, 8'h11);
    host_u.wr(ADDR_QCTRL, 8'h90);
    for (int i = 0; i < 255; i++)
    begin
      host_u.wr(ADDR_DATA, 8'(i));
    end
    rc(ADDR_COUNT, 8'hff);
    rc(ADDR_QCTRL, 8'hc0);
    host_u.wr(ADDR_DATA, 8'h5a);
    chk({7'h0, ovf}, 8'h01);
    rc(ADDR_COUNT, 8'hff);
    $display("queue done");
  endtask
  task automatic report_and_stop;
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  initial
  begin
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    #1;
    t_flags;
    t_events;
    t_cmd;
    t_queue;
    report_and_stop;
  end
  initial
  begin
    repeat (20000) @(posedge clk);
    failures++;
    report_and_stop;
  end
endmodule
